// >>> hdl/nrc_cfg.svh
// Constants for the NAND read command controller: codes, address layout, timing.
// Assumes a 20 MHz system clock; included by bare name from design files.
`ifndef NRC_CFG_SVH
`define NRC_CFG_SVH

// Command codes
`define NRC_CMD_READ_SETUP   8'h00
`define NRC_CMD_READ_CONFIRM 8'h30
`define NRC_CMD_COL_CHANGE   8'h05
`define NRC_CMD_COL_CONFIRM  8'hE0
`define NRC_CMD_READ_ID      8'h90
`define NRC_CMD_PARAM_PAGE   8'hEC
`define NRC_CMD_STATUS       8'h70

// Address values
`define NRC_ID_ADDR_DEVICE   8'h00
`define NRC_ID_ADDR_SIG      8'h20
`define NRC_PARAM_ADDR       8'h00
`define NRC_COL_HI_POS       8
`define NRC_ROW_HI_POS       8

// Page geometry and address cycle counts
`define NRC_PAGE_BYTES       2112
`define NRC_ADDR_FULL        3'd4
`define NRC_ADDR_COL         3'd2
`define NRC_ADDR_ONE         3'd1

// Timing
`define NRC_CLK_NS           50
`define NRC_STROBE_NS        50
`define NRC_SETTLE_NS        100
`define NRC_XFER_TIME_US     25
`define NRC_XFER_MARGIN      2
`define NRC_SYNC_CYC         3
`define NRC_STB_CYC    ((`NRC_STROBE_NS + `NRC_CLK_NS - 1) / `NRC_CLK_NS)
`define NRC_SETTLE_CYC ((`NRC_SETTLE_NS + `NRC_CLK_NS - 1) / `NRC_CLK_NS)
`define NRC_XFER_CYC   ((`NRC_XFER_TIME_US * 1000 * `NRC_XFER_MARGIN) / `NRC_CLK_NS)

`endif

// >>> hdl/nrc_ctrl.sv
// Host-side read controller for an 8-bit parallel NAND flash device.
// Assumes the device pins are wired straight to the pin ports and the
// testbench resolves io from io_out/io_oe; one 20 MHz clock, no software.
//
// Summary of operation
// - Full address is four cycles: two column bytes, then row low and high.
// - Upper four bus bits are driven low in the second address cycle.
// - Only defined command codes are ever issued.
// - Page read is setup, four address cycles, confirm; confirm starts transfer.
// - After polling status during a read, reissue read setup before data.
// - Column change is change code, two column cycles, confirm; then read.
// - Column change commands only move within one page.
`default_nettype none
`include "nrc_cfg.svh"
module nrc_ctrl #(
  parameter int PAGE_BYTES = `NRC_PAGE_BYTES,
  parameter int COUNT_W    = 12
) (
  input  wire logic            clk_sys,
  input  wire logic            srst,
  input  wire logic            start,
  input  wire nrc_pkg::nrc_op_t op,
  input  wire logic [11:0]     col_addr,
  input  wire logic [15:0]     row_addr,
  input  wire logic [7:0]      id_addr,
  input  wire logic [COUNT_W-1:0] rd_len,
  output logic                 busy,
  output logic                 done,
  output logic                 error,
  output logic [7:0]           rd_data,
  output logic                 rd_valid,
  output logic                 rd_last,
  output logic                 ce_n,
  output logic                 cle,
  output logic                 ale,
  output logic                 we_n,
  output logic                 read_strobe_n,
  output logic [7:0]           io_out,
  output logic                 io_oe,
  input  wire logic [7:0]      io_in,
  input  wire logic            ready_busy_n
);
  import nrc_pkg::*;

  localparam logic [9:0] STB    = 10'(`NRC_STB_CYC - 1);
  // Three register stages stand between the pin and level, so both waits cover them
  localparam logic [9:0] RLOW   = 10'(`NRC_STB_CYC + `NRC_SYNC_CYC);
  localparam logic [9:0] SETTLE = 10'(`NRC_SETTLE_CYC + `NRC_SYNC_CYC - 1);
  localparam logic [9:0] XFER   = 10'(`NRC_XFER_CYC - 1);

  // Elaboration checks
  if (PAGE_BYTES >= (1 << COUNT_W) || PAGE_BYTES > 4095) begin : g_chk_page
    $error("PAGE_BYTES does not fit the counters");
  end
  if (`NRC_XFER_CYC > 1023 || `NRC_STB_CYC < 1) begin : g_chk_time
    $error("Timing counts do not fit the timer");
  end

  nrc_sync_if #(.W(1)) rb_if ();
  nrc_sync_if #(.W(8)) io_if ();

  nrc_pin_sync #(.W(1), .RST_VAL(1'b1)) u_rb_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .port    (rb_if)
  );
  nrc_pin_sync #(.W(8), .RST_VAL(8'h00)) u_io_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .port    (io_if)
  );
  assign rb_if.raw = ready_busy_n;
  assign io_if.raw = io_in;

  nrc_state_t   state;
  nrc_state_t   next_state;
  logic         phase;
  logic         next_phase;
  logic [9:0]   tmr;
  logic [9:0]   next_tmr;
  logic [1:0]   idx;
  logic [1:0]   next_idx;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic [7:0]   addr_byte [4];
  logic [2:0]   addr_num;
  logic [7:0]   cmd1;
  logic [7:0]   cmd2;
  logic         has_cmd2;
  logic         need_wait;
  logic         has_tail;
  logic         emit;
  logic         next_err;

  // Per-operation decode at the start request
  wire          op_page    = (op == OP_PAGE_READ);
  wire          op_col     = (op == OP_COL_CHANGE);
  wire          op_id      = (op == OP_READ_ID);
  wire          op_param   = (op == OP_PARAM_PAGE);
  wire          op_status  = (op == OP_STATUS);
  wire          id_ok      = (id_addr == `NRC_ID_ADDR_DEVICE) ||
                             (id_addr == `NRC_ID_ADDR_SIG);
  wire [COUNT_W-1:0] page_sz = COUNT_W'(PAGE_BYTES);
  wire [COUNT_W-1:0] col_w   = COUNT_W'(col_addr);
  wire [COUNT_W-1:0] avail   = page_sz - col_w;
  wire          col_ok     = (col_w < page_sz);
  wire [COUNT_W-1:0] clamp_len = (rd_len > avail) ? avail : rd_len;
  wire          op_ok      = (op_page || op_col) ? (col_ok && rd_len != '0) :
                             op_id ? (id_ok && rd_len != '0) :
                             op_param ? (rd_len != '0) : op_status;
  wire [COUNT_W-1:0] start_len = (op_page || op_col) ? clamp_len :
                                 op_status ? COUNT_W'(1) : rd_len;
  wire [7:0]    start_cmd1 = op_page  ? `NRC_CMD_READ_SETUP :
                             op_col   ? `NRC_CMD_COL_CHANGE :
                             op_id    ? `NRC_CMD_READ_ID :
                             op_param ? `NRC_CMD_PARAM_PAGE : `NRC_CMD_STATUS;
  wire [2:0]    start_anum = op_page ? `NRC_ADDR_FULL :
                             op_col  ? `NRC_ADDR_COL :
                             (op_id || op_param) ? `NRC_ADDR_ONE : 3'd0;
  wire [7:0]    col_hi     = {4'h0, col_addr[11:`NRC_COL_HI_POS]};
  wire [7:0]    first_addr = op_id ? id_addr :
                             op_param ? `NRC_PARAM_ADDR : col_addr[7:0];

  // Where the write steps go once their last command or address byte is out
  wire          last_addr  = ({1'b0, idx} == 3'(addr_num - 3'd1));
  nrc_state_t   after_cmd;
  assign after_cmd = need_wait ? ST_SETTLE : ST_READ;

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_tmr   = tmr;
    next_idx   = idx;
    next_count = count;
    emit       = 1'b0;
    next_err   = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start) begin
          if (op_ok) begin
            next_state = ST_CMD1;
            next_phase = 1'b0;
            next_tmr   = STB;
            next_idx   = 2'd0;
            next_count = start_len;
          end else begin
            next_err = 1'b1;
          end
        end
      end
      ST_CMD1, ST_ADDR, ST_CMD2, ST_TAIL: begin
        if (tmr != '0) begin
          next_tmr = tmr - 10'd1;
        end else if (!phase) begin
          next_phase = 1'b1;
          next_tmr   = STB;
        end else begin
          next_phase = 1'b0;
          next_tmr   = STB;
          if (state == ST_CMD1) begin
            if (addr_num != 3'd0) begin
              next_state = ST_ADDR;
            end else begin
              next_state = has_cmd2 ? ST_CMD2 : after_cmd;
            end
          end else if (state == ST_ADDR) begin
            if (last_addr) begin
              next_state = has_cmd2 ? ST_CMD2 : after_cmd;
            end else begin
              next_idx = idx + 2'd1;
            end
          end else if (state == ST_CMD2) begin
            next_state = after_cmd;
          end else begin
            next_state = ST_IDLE;
          end
          if (next_state == ST_READ) begin
            next_tmr = RLOW;
          end else if (next_state == ST_SETTLE) begin
            next_tmr = SETTLE;
          end
        end
      end
      // Give the device time to pull ready/busy low before watching it
      ST_SETTLE: begin
        if (tmr != '0) begin
          next_tmr = tmr - 10'd1;
        end else begin
          next_state = ST_WAIT;
          next_tmr   = XFER;
        end
      end
      ST_WAIT: begin
        if (rb_if.level[0]) begin
          next_state = ST_READ;
          next_phase = 1'b0;
          next_tmr   = RLOW;
        end else if (tmr == '0) begin
          next_err   = 1'b1;
          next_state = ST_READ;
          next_phase = 1'b0;
          next_tmr   = RLOW;
        end else begin
          next_tmr = tmr - 10'd1;
        end
      end
      // Low phase is stretched by the synchroniser latency before sampling
      ST_READ: begin
        if (tmr != '0) begin
          next_tmr = tmr - 10'd1;
        end else if (!phase) begin
          emit       = 1'b1;
          next_phase = 1'b1;
          next_tmr   = STB;
        end else begin
          next_count = count - COUNT_W'(1);
          next_phase = 1'b0;
          if (count == COUNT_W'(1)) begin
            next_state = has_tail ? ST_TAIL : ST_IDLE;
            next_tmr   = STB;
          end else begin
            next_tmr = RLOW;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Pin levels for the coming cycle
  wire          w_cmd      = (next_state == ST_CMD1) || (next_state == ST_CMD2) ||
                             (next_state == ST_TAIL);
  wire          w_any      = w_cmd || (next_state == ST_ADDR);
  wire [7:0]    w_byte     = (next_state == ST_CMD1) ? cmd1 :
                             (next_state == ST_CMD2) ? cmd2 :
                             (next_state == ST_TAIL) ? `NRC_CMD_READ_SETUP :
                             addr_byte[next_idx];
  wire          next_ce_n  = (next_state == ST_IDLE);
  wire          next_we_n  = !(w_any && !next_phase);
  wire          next_re_n  = !((next_state == ST_READ) && !next_phase);

  // Latch operation parameters on an accepted start
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      addr_num  <= 3'd0;
      cmd1      <= `NRC_CMD_READ_SETUP;
      cmd2      <= `NRC_CMD_READ_CONFIRM;
      has_cmd2  <= 1'b0;
      need_wait <= 1'b0;
      has_tail  <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        addr_byte[i] <= 8'h00;
      end
    end else if (state == ST_IDLE && start && op_ok) begin
      addr_num     <= start_anum;
      cmd1         <= start_cmd1;
      cmd2         <= op_col ? `NRC_CMD_COL_CONFIRM : `NRC_CMD_READ_CONFIRM;
      has_cmd2     <= op_page || op_col;
      need_wait    <= op_page || op_param;
      has_tail     <= op_status;
      addr_byte[0] <= first_addr;
      addr_byte[1] <= col_hi;
      addr_byte[2] <= row_addr[7:0];
      addr_byte[3] <= row_addr[15:`NRC_ROW_HI_POS];
    end
  end

  // Sequencer state and timers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_IDLE;
      phase <= 1'b0;
      tmr   <= 10'd0;
      idx   <= 2'd0;
      count <= '0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      tmr   <= next_tmr;
      idx   <= next_idx;
      count <= next_count;
    end
  end

  // Registered pins; bus driven only during write steps
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ce_n          <= 1'b1;
      cle           <= 1'b0;
      ale           <= 1'b0;
      we_n          <= 1'b1;
      read_strobe_n <= 1'b1;
      io_out        <= 8'h00;
      io_oe         <= 1'b0;
    end else begin
      ce_n          <= next_ce_n;
      cle           <= w_cmd;
      ale           <= (next_state == ST_ADDR);
      we_n          <= next_we_n;
      read_strobe_n <= next_re_n;
      io_out        <= w_any ? w_byte : 8'h00;
      io_oe         <= w_any;
    end
  end

  // User-side status and data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy     <= 1'b0;
      done     <= 1'b0;
      error    <= 1'b0;
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
      rd_last  <= 1'b0;
    end else begin
      busy     <= (next_state != ST_IDLE);
      done     <= (state != ST_IDLE) && (next_state == ST_IDLE);
      error    <= next_err;
      rd_valid <= emit;
      rd_last  <= emit && (count == COUNT_W'(1));
      if (emit) begin
        rd_data <= io_if.level;
      end
    end
  end

endmodule
`default_nettype wire

// >>> hdl/nrc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes raw comes from a pin outside the clk_sys domain.
`default_nettype none
module nrc_pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic     clk_sys,
  input  wire logic     srst,
  nrc_sync_if.sync      port
);
  import nrc_pkg::*;

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] level;

  // Level only moves once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1    <= RST_VAL;
      s2    <= RST_VAL;
      s3    <= RST_VAL;
      level <= RST_VAL;
    end else begin
      s1 <= port.raw;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

  assign port.level = level;
endmodule
`default_nettype wire

// >>> hdl/nrc_pkg.sv
// Types for the NAND read command controller.
// Assumes nothing of its surroundings.
`default_nettype none
package nrc_pkg;
  // User operations
  typedef enum logic [2:0] {
    OP_PAGE_READ,
    OP_COL_CHANGE,
    OP_READ_ID,
    OP_PARAM_PAGE,
    OP_STATUS
  } nrc_op_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD1,
    ST_ADDR,
    ST_CMD2,
    ST_SETTLE,
    ST_WAIT,
    ST_READ,
    ST_TAIL
  } nrc_state_t;
endpackage
`default_nettype wire

// >>> hdl/nrc_sync_if.sv
// Carrier between the controller and its pin synchronisers.
// Assumes raw is driven by the controller and level by the synchroniser.
`default_nettype none
interface nrc_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  modport user (output raw, input level);
  modport sync (input raw, output level);
endinterface
`default_nettype wire

// >>> verification/nrc_ctrl_props.sv
// Checker for the NAND read controller pins and user handshake.
// Assumes it is bound to nrc_ctrl and sees only its ports.
`default_nettype none
module nrc_ctrl_props (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       busy,
  input wire logic       rd_valid,
  input wire logic       rd_last,
  input wire logic       ce_n,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       we_n,
  input wire logic       read_strobe_n,
  input wire logic [7:0] io_out,
  input wire logic       io_oe,
  input wire logic       ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [2:0] n_adr;
  // Address bytes since last command; the second carries the column high nibble
  always_ff @(posedge clk_sys) begin
    if (srst || (cle && !we_n)) n_adr <= 3'd0;
    else if (ale && $rose(we_n)) n_adr <= n_adr + 3'd1;
  end
  // Strobe shapes: read low five cycles to cover sync latency, write low one
  sequence s_rd_pulse;
    !read_strobe_n [*5] ##1 read_strobe_n;
  endsequence
  sequence s_wr_pulse;
    !we_n ##1 we_n;
  endsequence
  property p_rd_len;
    $fell(read_strobe_n) |-> s_rd_pulse;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe width wrong");
  property p_wr_len;
    $fell(we_n) |-> s_wr_pulse;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe width wrong");
  property p_wr_qual;
    !we_n |-> !ce_n && io_oe && (cle ^ ale);
  endproperty
  a_wr_qual: assert property (p_wr_qual) else $error("write not qualified");
  property p_rd_quiet;
    !read_strobe_n |-> !ce_n && !io_oe && !cle && !ale;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("bus driven during read");
  property p_col_high;
    (ale && !we_n && n_adr == 3'd1) |-> io_out[7:4] == 4'h0;
  endproperty
  a_col_high: assert property (p_col_high) else $error("second address high bits set");
  property p_cmd_code;
    (cle && !we_n) |-> io_out inside {8'h00, 8'h30, 8'h05, 8'hE0, 8'h90, 8'hEC, 8'h70};
  endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("undefined command code");
  property p_rdy_wait;
    $fell(read_strobe_n) |-> ready_busy_n && $past(ready_busy_n, 2);
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("read while device busy");
  property p_ce_busy;
    busy |-> !ce_n;
  endproperty
  a_ce_busy: assert property (p_ce_busy) else $error("chip enable off while busy");
  property p_last;
    rd_last |-> rd_valid ##1 !rd_valid;
  endproperty
  a_last: assert property (p_last) else $error("last flag without single byte");
endmodule
`default_nettype wire

// >>> verification/nrc_dev_model.sv
// Behavioural NAND device: command, address, page, id, parameter and status reads.
// Assumes the bench feeds io_in to the controller; ready_busy_n is pulled up.
`default_nettype none
module nrc_dev_model (
  input  wire logic       clk_sys,
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       read_strobe_n,
  input  wire logic       io_oe,
  input  wire logic [7:0] io_out,
  output logic      [7:0] io_in,
  output logic            ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int XFER = 40; // Short transfer keeps the run brief
  localparam logic [7:0] ID_BYTES [5] = '{8'h3C, 8'hA7, 8'h00, 8'h1D, 8'h00}; // Arbitrary
  localparam logic [7:0] SIG [4] = '{8'h4F, 8'h4E, 8'h46, 8'h49};
  logic [7:0]  ab [4];
  logic [7:0]  dout;
  logic [7:0]  last = 8'h00;
  logic [11:0] col = 12'h000;
  logic [15:0] row = 16'h0000;
  logic        rb_low = 1'b0;
  int          na = 0;
  int          mode = 0; // Page read mode from power-on
  int          stat = 0;
  function automatic logic [7:0] page_byte(logic [15:0] r, logic [11:0] c);
    return c[7:0] ^ r[7:0] ^ r[15:8] ^ {4'h0, c[11:8]};
  endfunction
  function automatic logic [7:0] par_byte(logic [11:0] c);
    return c[7:0] ^ 8'h5A; // Copies repeat every 256 bytes
  endfunction
  // Commands and addresses latch on write strobe rise
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      na = 0;
      stat = (io_out == 8'h70);
      if (io_out == 8'h30) begin
        col = {ab[1][3:0], ab[0]};
        row = {ab[3], ab[2]};
        mode = 0;
      end
      if (io_out == 8'hE0) col = {ab[1][3:0], ab[0]};
      if (io_out == 8'h90 || io_out == 8'hEC) col = 12'h000;
      if (io_out == 8'h90) mode = 1; // Held until the next 30h or ECh command
      if (io_out == 8'hEC) mode = 2;
      if (io_out == 8'h30 || io_out == 8'hEC) fork
        begin
          rb_low = 1'b1;
          repeat (XFER) @(posedge clk_sys);
          rb_low = 1'b0;
        end
      join_none
    end else if (!ce_n && ale) begin
      if (na < 4) ab[na] = io_out; // Extra cycles dropped
      na++;
    end
  end
  // Column steps on every read pulse
  always @(posedge read_strobe_n) if (!ce_n) col = col + 12'h001;
  // Output byte selection; past the page end the bus is not meaningful
  assign dout = stat != 0 ? {2'b00, ~rb_low, 5'b00000} :
                mode == 1 ? (ab[0] == 8'h20 ? SIG[col[1:0]] : ID_BYTES[col % 5]) :
                mode == 2 ? par_byte(col) :
                col < 12'd2112 ? page_byte(row, col) : ~last;
  // Released bus shows a changing value, never a stale byte
  assign io_in = io_oe ? io_out : (!ce_n && !read_strobe_n) ? dout : ~last;
  always @(posedge clk_sys) last <= io_in;
  assign ready_busy_n = rb_low ? 1'b0 : 1'b1; // Open drain with pull-up
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the NAND read controller against the device model.
// Assumes nrc_pkg, nrc_ctrl and nrc_dev_model are compiled first.
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  import nrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        start = 1'b0;
  nrc_op_t     op = OP_PAGE_READ;
  logic [11:0] col_addr = 12'h000;
  logic [11:0] rd_len = 12'h000;
  logic [15:0] row_addr = 16'h0000;
  logic [7:0]  id_addr = 8'h00;
  logic [7:0]  rd_data, io_out, io_in;
  logic        busy, done, error, rd_valid, rd_last, ce_n, cle, ale;
  logic        we_n, read_strobe_n, io_oe, ready_busy_n;
  logic        err_seen, last_ok, act, bsy;
  logic [7:0]  q [$];
  int          n_mismatch = 0;
  int          compares = 0;
  always #25 clk_sys = ~clk_sys;
  nrc_ctrl uut (.clk_sys(clk_sys), .srst(srst), .start(start), .op(op), .col_addr(col_addr),
    .row_addr(row_addr), .id_addr(id_addr), .rd_len(rd_len), .busy(busy), .done(done),
    .error(error), .rd_data(rd_data), .rd_valid(rd_valid), .rd_last(rd_last), .ce_n(ce_n),
    .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
    .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n));
  nrc_dev_model dev (.clk_sys(clk_sys), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .io_oe(io_oe), .io_out(io_out), .io_in(io_in),
    .ready_busy_n(ready_busy_n));
  // One request, then gather bytes until done or a refusal settles
  task automatic run(input nrc_op_t o, input logic [11:0] c, input logic [15:0] r,
                     input logic [7:0] i, input logic [11:0] n);
    int k;
    q.delete();
    err_seen = 1'b0;
    last_ok = 1'b0;
    act = 1'b0;
    bsy = 1'b0;
    @(negedge clk_sys);
    op = o;
    col_addr = c;
    row_addr = r;
    id_addr = i;
    rd_len = n;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    for (k = 0; k < 20000; k++) begin
      if (error === 1'b1) err_seen = 1'b1;
      if (ce_n !== 1'b1) act = 1'b1;
      if (busy === 1'b1) bsy = 1'b1;
      if (rd_valid === 1'b1) begin
        q.push_back(rd_data);
        last_ok = rd_last;
      end
      if (done === 1'b1 || (err_seen && busy === 1'b0)) break;
      @(negedge clk_sys);
    end
    `CHK("run ended", 1, int'(k < 20000))
  endtask
  task automatic chk_page(input logic [11:0] c, input logic [15:0] r, input int n);
    int k;
    `CHK("byte count", n, q.size())
    for (k = 0; k < q.size(); k++) `CHK("page byte", dev.page_byte(r, c + 12'(k)), q[k])
    `CHK("last flag", 1'b1, last_ok)
    `CHK("busy seen", 1'b1, bsy)
  endtask
  // Bad arguments: error pulse and the chip stays deselected
  task automatic t_refuse();
    int k;
    for (k = 0; k < 3; k++) begin
      case (k)
        0: run(OP_PAGE_READ, 12'h840, 16'h0000, 8'h00, 12'd1);
        1: run(OP_READ_ID, 12'h000, 16'h0000, 8'h10, 12'd5);
        default: run(OP_PARAM_PAGE, 12'h000, 16'h0000, 8'h00, 12'd0);
      endcase
      `CHK("refused", 1'b1, err_seen)
      `CHK("pins idle", 1'b0, act)
      `CHK("busy quiet", 1'b0, bsy)
    end
    $display("test refuse done");
  endtask
  // Status poll, then a page read must still return array data
  task automatic t_status();
    run(OP_STATUS, 12'h000, 16'h0000, 8'h00, 12'd1);
    `CHK("status ready", 8'h20, q[0])
    run(OP_PAGE_READ, 12'h010, 16'h0BEE, 8'h00, 12'd3);
    chk_page(12'h010, 16'h0BEE, 3);
    $display("test status done");
  endtask
  // Clamp at page end, then a back-to-back read elsewhere
  task automatic t_page();
    run(OP_PAGE_READ, 12'h83E, 16'hA55A, 8'h00, 12'd10);
    chk_page(12'h83E, 16'hA55A, 2);
    run(OP_PAGE_READ, 12'h0C3, 16'h0102, 8'h00, 12'd4);
    chk_page(12'h0C3, 16'h0102, 4);
    $display("test page done");
  endtask
  // Repeated column changes inside the loaded page
  task automatic t_col();
    run(OP_COL_CHANGE, 12'h800, 16'h0000, 8'h00, 12'd3);
    chk_page(12'h800, 16'h0102, 3);
    run(OP_COL_CHANGE, 12'h005, 16'h0000, 8'h00, 12'd2);
    chk_page(12'h005, 16'h0102, 2);
    $display("test column done");
  endtask
  task automatic t_id();
    int k;
    run(OP_READ_ID, 12'h000, 16'h0000, 8'h00, 12'd5);
    `CHK("id count", 5, q.size())
    for (k = 0; k < q.size(); k++) `CHK("id byte", dev.ID_BYTES[k], q[k])
    run(OP_READ_ID, 12'h000, 16'h0000, 8'h20, 12'd4);
    `CHK("sig count", 4, q.size())
    for (k = 0; k < q.size(); k++) `CHK("sig byte", dev.SIG[k], q[k])
    $display("test id done");
  endtask
  // Parameter page, then jump to the second copy
  task automatic t_param();
    int k;
    run(OP_PARAM_PAGE, 12'h000, 16'h0000, 8'h00, 12'd6);
    `CHK("param count", 6, q.size())
    for (k = 0; k < q.size(); k++) `CHK("param byte", dev.par_byte(12'(k)), q[k])
    run(OP_COL_CHANGE, 12'h100, 16'h0000, 8'h00, 12'd3);
    `CHK("copy count", 3, q.size())
    for (k = 0; k < q.size(); k++) `CHK("copy byte", dev.par_byte(12'(k)), q[k])
    $display("test param done");
  endtask
  task automatic finish_test();
    $display("Counts: %0d mismatches, %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    srst = 1'b0;
    t_refuse();
    t_status();
    t_page();
    t_col();
    t_id();
    t_param();
    finish_test();
  end
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(40000 * 50);
    n_mismatch++;
    finish_test();
  end
endmodule
bind nrc_ctrl nrc_ctrl_props u_props (.clk_sys(clk_sys), .srst(srst), .busy(busy),
  .rd_valid(rd_valid), .rd_last(rd_last), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
  .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe), .ready_busy_n(ready_busy_n));
`default_nettype wire
